/* qwr_cfg.svh */
/*
  Constant names for the serial word receiver: word size, reset values and the
  idle levels of the input pins.
  Assumes it is included by bare name wherever a constant is needed.
*/
`ifndef QWR_CFG_SVH
`define QWR_CFG_SVH

// =============================================================
// word layout
`define QWR_WORD_BITS   16
`define QWR_CNT_BITS    5
`define QWR_WORD_RST    16'h0000
`define QWR_CNT_RST     5'h00
`define QWR_CNT_ONE     5'h01

// =============================================================
// pin levels at reset: frame sync idles high, serial clock idles high
`define QWR_PIN_IDLE_HI 1'b1
`define QWR_PIN_IDLE_LO 1'b0

`endif

/* qwr_pkg.sv */
/*
  Types shared by the serial word receiver modules.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package qwr_pkg;

  // =============================================================
  // frame state
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_SHIFT,
    ST_DONE
  } frame_state_type;

endpackage

/* qwr_word_if.sv */
/*
  Valid/ready word carrier between the frame receiver and its word buffer.
  Assumes both ends run on the same clock.
*/
interface qwr_word_if #(
  parameter int WIDTH = 16
);
  logic             valid;
  logic             ready;
  logic [WIDTH-1:0] data;

  modport source (output valid, output data, input ready);
  modport sink   (input valid, input data, output ready);
endinterface

/* qwr_word_buffer.sv */
/*
  Two-entry word buffer: a head register feeding the outputs directly and one
  spare register, so a downstream stall loses no word.
  Assumes a synchronous active-low reset on the same clock as both sides.
*/
`include "qwr_cfg.svh"

module qwr_word_buffer #(
  parameter int WIDTH = `QWR_WORD_BITS
) (
  // clock and reset
  input  wire logic             i_clk,
  input  wire logic             i_reset_n,
  // filling side
  qwr_word_if.sink              in_port,
  // draining side
  output logic                  o_valid,
  output logic [WIDTH-1:0]      o_data,
  input  wire logic             i_ready
);

  // =============================================================
  // storage
  logic             head_v_r;
  logic [WIDTH-1:0] head_d_r;
  logic             spare_v_r;
  logic [WIDTH-1:0] spare_d_r;

  // handshake terms
  wire pop  = head_v_r & i_ready;
  wire push = in_port.valid & ~spare_v_r;

  // ready comes from a flop, so the source never sees a combinational loop
  assign in_port.ready = ~spare_v_r;
  assign o_valid       = head_v_r;
  assign o_data        = head_d_r;

  // =============================================================
  // head and spare update; spare only fills while head is stalled
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      head_v_r  <= 1'b0;
      head_d_r  <= `QWR_WORD_RST;
      spare_v_r <= 1'b0;
      spare_d_r <= `QWR_WORD_RST;
    end else if (spare_v_r) begin
      if (pop) begin
        head_d_r  <= spare_d_r;
        spare_v_r <= 1'b0;
      end
    end else if (head_v_r && !pop) begin
      if (push) begin
        spare_d_r <= in_port.data;
        spare_v_r <= 1'b1;
      end
    end else begin
      head_v_r <= push;
      if (push) begin
        head_d_r <= in_port.data;
      end
    end
  end

endmodule

/* qwr_receiver.sv */
/*
  Write-only three-wire serial word receiver with frame abort, input buffer
  power-down indication and a buffered word output.
  Assumes the frame sync, serial clock and data pins are asynchronous to i_clk
  and that the serial clock runs at most a quarter of the i_clk rate.
*/
// Contract
// - shift register exactly sixteen bits wide
// - data shifted in on serial clock falls
// - sync low starts frame of sixteen falls
// - early sync rise aborts and discards word
// - input buffers powered down after each write
// - reset clears all registers to zero; the sync and sclk synchroniser flops and sync_prev_r reset high instead
`include "qwr_cfg.svh"

module qwr_receiver #(
  parameter int WORD_BITS = `QWR_WORD_BITS
) (
  // clock and reset
  input  wire logic                 i_clk,
  input  wire logic                 i_reset_n,
  // serial pins
  input  wire logic                 i_sync_n,
  input  wire logic                 i_sclk,
  input  wire logic                 i_sdata,
  // word output toward command decode
  output logic                      o_word_valid,
  output logic [WORD_BITS-1:0]      o_word,
  input  wire logic                 i_word_ready,
  // status
  output logic                      o_input_power_down,
  output logic                      o_overrun
);

  // =============================================================
  // pin synchronisers, two flops each, third sclk flop for edges
  logic sync_s1_r;
  logic sync_s2_r;
  logic sclk_s1_r;
  logic sclk_s2_r;
  logic sclk_s3_r;
  logic din_s1_r;
  logic din_s2_r;

  // first stages feed only the second stages
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      sync_s1_r <= `QWR_PIN_IDLE_HI;
      sync_s2_r <= `QWR_PIN_IDLE_HI;
      sclk_s1_r <= `QWR_PIN_IDLE_HI;
      sclk_s2_r <= `QWR_PIN_IDLE_HI;
      sclk_s3_r <= `QWR_PIN_IDLE_HI;
      din_s1_r  <= `QWR_PIN_IDLE_LO;
      din_s2_r  <= `QWR_PIN_IDLE_LO;
    end else begin
      sync_s1_r <= i_sync_n;
      sync_s2_r <= sync_s1_r;
      sclk_s1_r <= i_sclk;
      sclk_s2_r <= sclk_s1_r;
      sclk_s3_r <= sclk_s2_r;
      din_s1_r  <= i_sdata;
      din_s2_r  <= din_s1_r;
    end
  end

  // =============================================================
  // frame control
  qwr_pkg::frame_state_type state_r;
  qwr_pkg::frame_state_type state_nxt;
  logic [WORD_BITS-1:0]     shift_r;
  logic [`QWR_CNT_BITS-1:0] bit_cnt_r;
  logic                     sync_prev_r;
  logic                     pend_r;
  logic [WORD_BITS-1:0]     pend_word_r;
  logic                     pdown_r;
  logic                     overrun_r;

  // edge and count decode; din_s2 lines up with sclk_s2 so bits stay paired
  wire                      sclk_fall = sclk_s3_r & ~sclk_s2_r;
  wire                      sync_fell = sync_prev_r & ~sync_s2_r;
  wire                      last_bit  = (bit_cnt_r == 5'(WORD_BITS - 1));
  wire                      shift_en  = (state_r == qwr_pkg::ST_SHIFT) & ~sync_s2_r & sclk_fall;
  wire                      word_done = shift_en & last_bit;
  wire [WORD_BITS-1:0]      shift_nxt = {shift_r[WORD_BITS-2:0], din_s2_r};

  // word carrier toward the buffer
  qwr_word_if #(.WIDTH(WORD_BITS)) word_bus ();
  assign word_bus.valid = pend_r;
  assign word_bus.data  = pend_word_r;
  wire   buf_take       = pend_r & word_bus.ready;

  // next state; sync high while shifting is an abort
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      qwr_pkg::ST_IDLE: begin
        if (sync_fell) begin
          state_nxt = qwr_pkg::ST_SHIFT;
        end
      end
      qwr_pkg::ST_SHIFT: begin
        if (sync_s2_r) begin
          state_nxt = qwr_pkg::ST_IDLE;
        end else if (word_done) begin
          state_nxt = qwr_pkg::ST_DONE;
        end
      end
      qwr_pkg::ST_DONE: begin
        if (sync_s2_r) begin
          state_nxt = qwr_pkg::ST_IDLE;
        end
      end
      default: begin
        state_nxt = qwr_pkg::ST_IDLE;
      end
    endcase
  end

  // state, sync history and power-down flag
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      state_r     <= qwr_pkg::ST_IDLE;
      sync_prev_r <= `QWR_PIN_IDLE_HI;
      pdown_r     <= 1'b0;
    end else begin
      state_r     <= state_nxt;
      sync_prev_r <= sync_s2_r;
      if (word_done) begin
        pdown_r <= 1'b1;
      end else if (sync_fell) begin
        pdown_r <= 1'b0;
      end
    end
  end

  // shifter and bit counter; a fresh frame restarts the count
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      shift_r   <= `QWR_WORD_RST;
      bit_cnt_r <= `QWR_CNT_RST;
    end else if (sync_fell) begin
      bit_cnt_r <= `QWR_CNT_RST;
    end else if (shift_en) begin
      shift_r   <= shift_nxt;
      bit_cnt_r <= bit_cnt_r + `QWR_CNT_ONE;
    end
  end

  // hold a finished word until the buffer takes it; a word arriving while one
  // still waits is counted as overrun since the host cannot be stalled;
  // the newer word then takes the waiting word's place
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      pend_r      <= 1'b0;
      pend_word_r <= `QWR_WORD_RST;
      overrun_r   <= 1'b0;
    end else if (word_done) begin
      pend_r      <= 1'b1;
      pend_word_r <= shift_nxt;
      overrun_r   <= overrun_r | (pend_r & ~buf_take);
    end else if (buf_take) begin
      pend_r <= 1'b0;
    end
  end

  assign o_input_power_down = pdown_r;
  assign o_overrun          = overrun_r;

  // =============================================================
  // word buffer; its outputs are flops and drive the ports directly
  qwr_word_buffer #(.WIDTH(WORD_BITS)) u_buffer (
    .i_clk     (i_clk),
    .i_reset_n (i_reset_n),
    .in_port   (word_bus),
    .o_valid   (o_word_valid),
    .o_data    (o_word),
    .i_ready   (i_word_ready)
  );

  // =============================================================
  // assertions
  property p_word_len;
    @(posedge i_clk) disable iff (!i_reset_n)
      $rose(pend_r) |-> $past(shift_en) && ($past(bit_cnt_r) == 5'(WORD_BITS - 1));
  endproperty
  a_word_len: assert property (p_word_len) else $error("word ended at wrong bit count");

  property p_shift_in;
    @(posedge i_clk) disable iff (!i_reset_n)
      (shift_en && !sync_fell) |=> (shift_r[0] == $past(din_s2_r))
        && (shift_r[WORD_BITS-1:1] == $past(shift_r[WORD_BITS-2:0]));
  endproperty
  a_shift_in: assert property (p_shift_in) else $error("bit not shifted on clock fall");

  property p_frame_start;
    @(posedge i_clk) disable iff (!i_reset_n)
      ($fell(sync_s2_r) && state_r == qwr_pkg::ST_IDLE)
        |=> (state_r == qwr_pkg::ST_SHIFT) && (bit_cnt_r == `QWR_CNT_RST);
  endproperty
  a_frame_start: assert property (p_frame_start) else $error("frame did not start");

  property p_abort;
    @(posedge i_clk) disable iff (!i_reset_n)
      (state_r == qwr_pkg::ST_SHIFT && sync_s2_r)
        |=> (state_r == qwr_pkg::ST_IDLE) && !$rose(pend_r) ##1 !$rose(pend_r);
  endproperty
  a_abort: assert property (p_abort) else $error("aborted frame produced a word");

  property p_pdown;
    @(posedge i_clk) disable iff (!i_reset_n)
      word_done |=> o_input_power_down && (state_r == qwr_pkg::ST_DONE);
  endproperty
  a_pdown: assert property (p_pdown) else $error("inputs not powered down after write");

  property p_reset_clear;
    @(posedge i_clk)
      !i_reset_n |=> (shift_r == `QWR_WORD_RST) && (o_word == `QWR_WORD_RST) && !o_word_valid;
  endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("reset left data set");

  property p_strobe;
    @(posedge i_clk) disable iff (!i_reset_n)
      word_done |=> pend_r && (pend_word_r == $past(shift_nxt));
  endproperty
  a_strobe: assert property (p_strobe) else $error("completed word not offered");

endmodule

/* serial_host_model.sv */
/*
  Host-side serial master model for the word receiver: frame sync, serial
  clock and data, driven from rising edges of the system clock.
  Assumes the bench calls send_frame and that i_clk runs at 40 ns.
*/
module serial_host_model (
  // clock
  input  wire logic i_clk,
  // pins toward the receiver
  output logic      o_sync_n,
  output logic      o_sclk,
  output logic      o_sdata
);
  timeunit 1ns;
  timeprecision 1ns;

  // =============================================================
  // frame driver
  // half period of 4 cycles gives a 320 ns serial clock
  localparam int HALF = 4;

  initial begin
    o_sync_n = 1'b1;
    o_sclk   = 1'b1;
    o_sdata  = 1'b0;
  end

  task automatic idle(input int n);
    repeat (n) @(posedge i_clk);
  endtask

  // msb of the given count goes first; sclk stands high outside frames
  task automatic send_frame(input logic [17:0] bits, input int nbits);
    int i;
    @(posedge i_clk);
    o_sync_n <= 1'b0;
    for (i = nbits - 1; i >= 0; i--) begin
      o_sdata <= bits[i];
      idle(HALF);
      o_sclk <= 1'b0;
      idle(HALF);
      o_sclk <= 1'b1;
    end
    idle(HALF);
    o_sync_n <= 1'b1;
    // released data line shows the inverse, not a stale copy
    o_sdata  <= ~o_sdata;
    idle(HALF);
  endtask
endmodule

/* quad_dac_serial_word_receiver_bench.sv */
/*
  Self-checking bench for the serial word receiver: reset, full word,
  abort, extra edges and a stalled buffer.
  Assumes serial_host_model stands on the pin side.
*/
`define CHECK(name, exp, got) \
  begin \
    check_count++; \
    if ((got) !== (exp)) begin \
      fails++; \
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got); \
    end \
  end

module quad_dac_serial_word_receiver_bench;
  timeunit 1ns;
  timeprecision 1ns;

  // =============================================================
  // signals
  logic        i_clk = 1'b0;
  logic        i_reset_n;
  logic        sync_n;
  logic        sclk;
  logic        sdata;
  logic        word_valid;
  logic [15:0] word;
  logic        word_ready;
  logic        power_down;
  logic        overrun;
  int          fails = 0;
  int          check_count = 0;

  always #20 i_clk = ~i_clk;

  qwr_receiver qwr_receiver_inst (
    .i_clk              (i_clk),
    .i_reset_n          (i_reset_n),
    .i_sync_n           (sync_n),
    .i_sclk             (sclk),
    .i_sdata            (sdata),
    .o_word_valid       (word_valid),
    .o_word             (word),
    .i_word_ready       (word_ready),
    .o_input_power_down (power_down),
    .o_overrun          (overrun)
  );

  serial_host_model serial_host_model_inst (
    .i_clk    (i_clk),
    .o_sync_n (sync_n),
    .o_sclk   (sclk),
    .o_sdata  (sdata)
  );

  // =============================================================
  // helpers
  // sample after the edge so its updates have landed
  task automatic settle();
    @(posedge i_clk);
    #1;
  endtask

  // bounded wait for a word, then compare it
  task automatic take_word(input logic [15:0] exp);
    int n;
    n = 0;
    settle();
    while (word_valid !== 1'b1 && n < 200) begin
      settle();
      n++;
    end
    `CHECK("valid", 1'b1, word_valid)
    `CHECK("word", exp, word)
  endtask

  // check the stalled head word, then grant ready for one sampling edge
  task automatic pop_word(input logic [15:0] exp);
    settle();
    `CHECK("valid", 1'b1, word_valid)
    `CHECK("word", exp, word)
    @(posedge i_clk);
    word_ready <= 1'b1;
    @(posedge i_clk);
    word_ready <= 1'b0;
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // =============================================================
  // scenarios
  task automatic test_reset();
    settle();
    `CHECK("valid", 1'b0, word_valid)
    `CHECK("word", 16'h0000, word)
    `CHECK("pd", 1'b0, power_down)
    `CHECK("overrun", 1'b0, overrun)
    $display("test reset done");
  endtask

  task automatic test_word();
    @(posedge i_clk);
    word_ready <= 1'b1;
    fork
      serial_host_model_inst.send_frame({2'h0, 16'hA5C3}, 16);
      begin
        take_word(16'hA5C3);
        settle();
        `CHECK("strobe", 1'b0, word_valid)
      end
    join
    `CHECK("pd", 1'b1, power_down)
    $display("test word done");
  endtask

  // fifteen edges then sync rise: nothing may come out
  task automatic test_abort();
    fork
      serial_host_model_inst.send_frame({3'h0, 15'h7FFF}, 15);
      begin
        repeat (6) settle();
        `CHECK("pd", 1'b0, power_down)
      end
    join
    repeat (20) settle();
    `CHECK("valid", 1'b0, word_valid)
    `CHECK("pd", 1'b0, power_down)
    // two edges past the sixteenth are ignored
    fork
      serial_host_model_inst.send_frame({16'h5A3C, 2'h1}, 18);
      take_word(16'h5A3C);
    join
    $display("test abort done");
  endtask

  // three words fit; a fourth overruns and replaces the waiting third
  task automatic test_stall();
    @(posedge i_clk);
    word_ready <= 1'b0;
    serial_host_model_inst.send_frame({2'h0, 16'hFFFF}, 16);
    serial_host_model_inst.send_frame({2'h0, 16'h0001}, 16);
    serial_host_model_inst.send_frame({2'h0, 16'h8000}, 16);
    serial_host_model_inst.send_frame({2'h0, 16'h7FFE}, 16);
    repeat (10) settle();
    `CHECK("overrun", 1'b1, overrun)
    // one ready edge per word: head, spare, then the newer pending word
    pop_word(16'hFFFF);
    pop_word(16'h0001);
    pop_word(16'h7FFE);
    repeat (10) settle();
    `CHECK("valid", 1'b0, word_valid)
    $display("test stall done");
  endtask

  // =============================================================
  // main sequence and watchdog
  initial begin
    i_reset_n  = 1'b0;
    word_ready = 1'b0;
    repeat (8) @(posedge i_clk);
    i_reset_n <= 1'b1;
    test_reset();
    repeat (3) @(posedge i_clk);
    test_word();
    test_abort();
    test_stall();
    finish_test();
  end

  // the tests need about 1030 cycles
  initial begin
    repeat (6000) @(posedge i_clk);
    fails++;
    finish_test();
  end
endmodule
